//--- mcvs_top.sv
// MCU control register with vector select and sleep brownout control
module mcvs_top
	import mcvs_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [7:0]  bus_addr,
	input  wire logic        bus_io,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	input  wire logic [7:0]  bus_wdata,
	output logic [7:0]       bus_rdata,
	output logic             bus_hit,
	input  wire logic        instr_done,
	input  wire logic        sleep_exec,
	input  wire logic        wake,
	input  wire logic [12:0] pc,
	input  wire logic        boot_reset_fuse,
	input  wire logic [1:0]  boot_size_fuse,
	input  wire logic        app_boot_lock_bit,
	input  wire logic        boot_boot_lock_bit,
	output logic             irq_block,
	output logic             pullup_global_off,
	output logic             bod_sleep_active,
	output logic             bod_off,
	output logic [12:0]      vector_base,
	output logic [12:0]      reset_addr
);

	// ---------------------------------------------------------------
	// Register access decode
	// ---------------------------------------------------------------
	logic hit;
	logic wr_hit;
	logic rd_hit;

	// Same register, two address spaces
	assign hit = bus_io ? (bus_addr == MCVS_IO_OFF)
		: (bus_addr == MCVS_DS_OFF);
	assign wr_hit = bus_wr && hit;
	assign rd_hit = bus_rd && hit;

	// ---------------------------------------------------------------
	// Register bits
	// ---------------------------------------------------------------
	logic vsel_q;
	logic vsel_d;
	logic pull_off_q;
	logic pull_off_d;
	logic slp_unlk_q;
	logic slp_unlk_d;
	logic slp_req_q;
	logic slp_req_d;
	logic chg_unlk_q;
	logic chg_unlk_d;

	logic w_chg_unlk;
	logic w_vsel;
	logic w_slp_unlk;
	logic w_slp_req;

	assign w_chg_unlk = bus_wdata[MCVS_B_CHG_UNLK];
	assign w_vsel     = bus_wdata[MCVS_B_VEC_SEL];
	assign w_slp_unlk = bus_wdata[MCVS_B_SLP_UNLK];
	assign w_slp_req  = bus_wdata[MCVS_B_SLP_REQ];

	// Sequence qualifiers
	logic chg_set;
	logic vsel_take;
	logic slp_unlk_set;
	logic slp_req_take;

	// Unlock write, or the completing write inside an open window
	assign chg_set      = wr_hit && w_chg_unlk;
	assign vsel_take    = wr_hit && !w_chg_unlk && chg_unlk_q;
	assign slp_unlk_set = wr_hit && w_slp_req && w_slp_unlk;
	assign slp_req_take = wr_hit && w_slp_req && !w_slp_unlk
		&& slp_unlk_q;

	// ---------------------------------------------------------------
	// Window timers
	// ---------------------------------------------------------------
	logic chg_open;
	logic slp_unlk_open;
	logic slp_req_open;

	// Change unlock lasts four cycles unless the select is written
	mcvs_window #(
		.CYCLES (MCVS_VCHG_CYC)
	) u_chg_win (
		.clock (clock),
		.rst_n (rst_n),
		.start (chg_set),
		.stop  (vsel_take),
		.open  (chg_open)
	);

	// Sleep unlock window for the request write
	mcvs_window #(
		.CYCLES (MCVS_SLPU_CYC)
	) u_slp_unlk_win (
		.clock (clock),
		.rst_n (rst_n),
		.start (slp_unlk_set),
		.stop  (slp_req_take),
		.open  (slp_unlk_open)
	);

	// Sleep request lifetime
	mcvs_window #(
		.CYCLES (MCVS_SLPR_CYC)
	) u_slp_req_win (
		.clock (clock),
		.rst_n (rst_n),
		.start (slp_req_take),
		.stop  (1'b0),
		.open  (slp_req_open)
	);

	// ---------------------------------------------------------------
	// Register next values
	// ---------------------------------------------------------------
	// Guarded bits change only through their sequence
	always_comb
	begin
		vsel_d     = vsel_q;
		pull_off_d = pull_off_q;
		chg_unlk_d = chg_open && !vsel_take;
		slp_unlk_d = slp_unlk_open && !slp_req_take;
		slp_req_d  = slp_req_open;
		if (chg_set)
			chg_unlk_d = 1'b1;
		if (slp_unlk_set)
			slp_unlk_d = 1'b1;
		if (slp_req_take)
			slp_req_d = 1'b1;
		if (vsel_take)
			vsel_d = w_vsel;
		if (wr_hit)
			pull_off_d = bus_wdata[MCVS_B_PULL_OFF];
	end

	// All implemented bits start at zero
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			chg_unlk_q <= MCVS_RESET_VAL[MCVS_B_CHG_UNLK];
			vsel_q     <= MCVS_RESET_VAL[MCVS_B_VEC_SEL];
			pull_off_q <= MCVS_RESET_VAL[MCVS_B_PULL_OFF];
			slp_unlk_q <= MCVS_RESET_VAL[MCVS_B_SLP_UNLK];
			slp_req_q  <= MCVS_RESET_VAL[MCVS_B_SLP_REQ];
		end
		else
		begin
			chg_unlk_q <= chg_unlk_d;
			vsel_q     <= vsel_d;
			pull_off_q <= pull_off_d;
			slp_unlk_q <= slp_unlk_d;
			slp_req_q  <= slp_req_d;
		end
	end

	// ---------------------------------------------------------------
	// Vector change blocking sequence
	// ---------------------------------------------------------------
	mcvs_vc_t vc_q;
	mcvs_vc_t vc_d;

	// Hold waits for the instruction after the select write to finish
	always_comb
	begin
		vc_d = vc_q;
		unique case (vc_q)
			MCVS_VC_IDLE:
			begin
				if (chg_set)
					vc_d = MCVS_VC_OPEN;
			end
			MCVS_VC_OPEN:
			begin
				if (vsel_take)
					vc_d = MCVS_VC_HOLD;
				else if (chg_set)
					vc_d = MCVS_VC_OPEN;
				else if (!chg_open)
					vc_d = MCVS_VC_IDLE;
			end
			MCVS_VC_HOLD:
			begin
				if (chg_set)
					vc_d = MCVS_VC_OPEN;
				else if (instr_done)
					vc_d = MCVS_VC_IDLE;
			end
			default:
				vc_d = MCVS_VC_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			vc_q <= MCVS_VC_IDLE;
		else
			vc_q <= vc_d;
	end

	// ---------------------------------------------------------------
	// Address map and lock suppression
	// ---------------------------------------------------------------
	logic [12:0] map_vec;
	logic [12:0] map_reset;
	logic        in_boot;
	logic        lock_sup;
	logic        irq_block_q;
	logic        irq_block_d;

	mcvs_vector_map u_map (
		.boot_size_fuse     (boot_size_fuse),
		.boot_reset_fuse    (boot_reset_fuse),
		.vector_base_select (vsel_q),
		.pc                 (pc),
		.boot_start         (),
		.reset_addr         (map_reset),
		.vector_base        (map_vec),
		.pc_in_boot         (in_boot)
	);

	// Lock bits are active low: zero means programmed
	assign lock_sup =
		(vsel_q && !app_boot_lock_bit && !in_boot) ||
		(!vsel_q && !boot_boot_lock_bit && in_boot);

	// Blocking is its own signal; the global enable flag lives elsewhere
	assign irq_block_d = (vc_d != MCVS_VC_IDLE) || lock_sup;

	// ---------------------------------------------------------------
	// Sleep brownout control
	// ---------------------------------------------------------------
	logic bod_off_q;
	logic bod_off_d;

	// Sleep only takes the detector down while the request is alive
	always_comb
	begin
		bod_off_d = bod_off_q;
		if (sleep_exec && slp_req_q)
			bod_off_d = 1'b1;
		else if (wake)
			bod_off_d = 1'b0;
	end

	// ---------------------------------------------------------------
	// Output and read data registers
	// ---------------------------------------------------------------
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic        hit_q;
	logic [12:0] vec_q;
	logic [12:0] rst_q;

	// Unmapped reads return zero; reserved bits read as zero
	always_comb
	begin
		rdata_d = 8'h00;
		if (rd_hit)
		begin
			rdata_d[MCVS_B_CHG_UNLK] = chg_unlk_q;
			rdata_d[MCVS_B_VEC_SEL]  = vsel_q;
			rdata_d[MCVS_B_PULL_OFF] = pull_off_q;
			rdata_d[MCVS_B_SLP_UNLK] = slp_unlk_q;
			rdata_d[MCVS_B_SLP_REQ]  = slp_req_q;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rdata_q     <= 8'h00;
			hit_q       <= 1'b0;
			irq_block_q <= 1'b0;
			bod_off_q   <= 1'b0;
			vec_q       <= MCVS_APP_RESET + MCVS_VEC_STEP;
			rst_q       <= MCVS_APP_RESET;
		end
		else
		begin
			rdata_q     <= rdata_d;
			hit_q       <= hit && (bus_rd || bus_wr);
			irq_block_q <= irq_block_d;
			bod_off_q   <= bod_off_d;
			vec_q       <= map_vec;
			rst_q       <= map_reset;
		end
	end

	assign bus_rdata         = rdata_q;
	assign bus_hit           = hit_q;
	assign irq_block         = irq_block_q;
	assign pullup_global_off = pull_off_q;
	assign bod_sleep_active  = slp_req_q;
	assign bod_off           = bod_off_q;
	assign vector_base       = vec_q;
	assign reset_addr        = rst_q;

endmodule

//--- mcvs_pkg.sv
// Notes on behaviour
// - Select 0 fetches vectors from flash start; select 1 from boot section start.
// - Boot section start, the relocated vector base, follows the boot size fuse.
// - Interrupts blocked from unlock set until the instruction after the select write.
// - Without a select write, interrupts stay blocked four cycles, then resume.
// - Temporary blocking never touches the global interrupt enable flag.
// - Change unlock clears four cycles after set, or at once on a select write.
// - Boot vectors plus application lock: no interrupts while running application code.
// - Application vectors plus boot lock: no interrupts while running boot code.
// - Request becomes usable for sleep; sleep then turns the brownout detector off.
// - Hardware clears the sleep request three cycles after it is set.
// - Global pull-up off disables every pull-up, whatever direction and output bits say.
// - Register answers at data offset 0x55 and I/O offset 0x35.
// - All implemented bits reset to zero.
// - Programmed boot reset with 1 Kbyte boot starts at 0x1C00, vectors 0x1C02.
// - Boot reset fuse 1 means reset to zero; 0 means boot reset address.
package mcvs_pkg;

	// ---------------------------------------------------------------
	// Register placement
	// ---------------------------------------------------------------
	localparam logic [7:0] MCVS_DS_OFF    = 8'h55;
	localparam logic [7:0] MCVS_IO_SHIFT  = 8'h20;
	localparam logic [7:0] MCVS_IO_OFF    = MCVS_DS_OFF - MCVS_IO_SHIFT;
	localparam logic [7:0] MCVS_RESET_VAL = 8'h00;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int MCVS_B_CHG_UNLK = 0;
	localparam int MCVS_B_VEC_SEL  = 1;
	localparam int MCVS_B_PULL_OFF = 4;
	localparam int MCVS_B_SLP_UNLK = 5;
	localparam int MCVS_B_SLP_REQ  = 6;

	// ---------------------------------------------------------------
	// Timing counts, in clock cycles
	// ---------------------------------------------------------------
	localparam int MCVS_VCHG_CYC = 4;
	localparam int MCVS_SLPU_CYC = 4;
	localparam int MCVS_SLPR_CYC = 3;

	// ---------------------------------------------------------------
	// Flash word addresses
	// ---------------------------------------------------------------
	localparam int MCVS_PCW = 13;
	localparam logic [12:0] MCVS_APP_RESET = 13'h0000;
	localparam logic [12:0] MCVS_VEC_STEP  = 13'h0002;
	localparam logic [12:0] MCVS_BOOT_256  = 13'h1F00;
	localparam logic [12:0] MCVS_BOOT_512  = 13'h1E00;
	localparam logic [12:0] MCVS_BOOT_1K   = 13'h1C00;
	localparam logic [12:0] MCVS_BOOT_2K   = 13'h1800;

	// Vector change sequence states, Gray along the path
	typedef enum logic [1:0]
	{
		MCVS_VC_IDLE = 2'b00,
		MCVS_VC_OPEN = 2'b01,
		MCVS_VC_HOLD = 2'b11
	} mcvs_vc_t;

endpackage

//--- mcvs_window.sv
// Holds a fixed-length window open after a start pulse
module mcvs_window
	import mcvs_pkg::*;
#(
	parameter int CYCLES = 4
)
(
	input  wire logic clock,
	input  wire logic rst_n,
	input  wire logic start,
	input  wire logic stop,
	output logic      open
);

	logic [3:0] cnt_q;
	logic [3:0] cnt_d;

	// Restart wins over stop so a fresh unlock is never lost.
	// The start cycle is the first cycle of the window, so the count
	// loads one less: a flag fed from open then lasts CYCLES cycles.
	always_comb
	begin
		cnt_d = cnt_q;
		if (start)
			cnt_d = 4'(CYCLES - 1);
		else if (stop)
			cnt_d = 4'h0;
		else if (cnt_q != 4'h0)
			cnt_d = cnt_q - 4'h1;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cnt_q <= 4'h0;
		else
			cnt_q <= cnt_d;
	end

	assign open = (cnt_q != 4'h0);

endmodule

//--- mcvs_vector_map.sv
// Flash addresses from fuses, select bit and program counter
module mcvs_vector_map
	import mcvs_pkg::*;
(
	input  wire logic [1:0]  boot_size_fuse,
	input  wire logic        boot_reset_fuse,
	input  wire logic        vector_base_select,
	input  wire logic [12:0] pc,
	output logic [12:0]      boot_start,
	output logic [12:0]      reset_addr,
	output logic [12:0]      vector_base,
	output logic             pc_in_boot
);

	// Boot section start from the size fuse
	always_comb
	begin
		unique case (boot_size_fuse)
			2'b11:   boot_start = MCVS_BOOT_256;
			2'b10:   boot_start = MCVS_BOOT_512;
			2'b01:   boot_start = MCVS_BOOT_1K;
			2'b00:   boot_start = MCVS_BOOT_2K;
		endcase
	end

	// Fuse value 1 is unprogrammed: reset to zero
	assign reset_addr  = boot_reset_fuse ? MCVS_APP_RESET : boot_start;
	assign vector_base = vector_base_select ? boot_start + MCVS_VEC_STEP
		: MCVS_APP_RESET + MCVS_VEC_STEP;
	assign pc_in_boot  = (pc >= boot_start);

endmodule

//--- mcvs_checker.sv
module mcvs_checker
	import mcvs_pkg::*;
(
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [7:0]  bus_addr,
	input wire logic        bus_io,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [7:0]  bus_wdata,
	input wire logic [7:0]  bus_rdata,
	input wire logic        bus_hit,
	input wire logic        sleep_exec,
	input wire logic        boot_reset_fuse,
	input wire logic [1:0]  boot_size_fuse,
	input wire logic        app_boot_lock_bit,
	input wire logic        boot_boot_lock_bit,
	input wire logic        irq_block,
	input wire logic        pullup_global_off,
	input wire logic        bod_sleep_active,
	input wire logic        bod_off,
	input wire logic [12:0] reset_addr
);
	timeunit 1ns;
	timeprecision 1ns;
	// ------------------------------------------------
	// Decode helpers
	// ------------------------------------------------
	wire logic hc = (bus_wr | bus_rd) &
		(bus_io ? bus_addr == MCVS_IO_OFF : bus_addr == MCVS_DS_OFF);
	wire logic rdh = bus_rd & hc;
	wire logic wu = bus_wr & hc & (bus_wdata[1:0] == 2'b01);
	wire logic nolock = app_boot_lock_bit & boot_boot_lock_bit;
	wire logic [12:0] bs = boot_size_fuse[1] ?
		(boot_size_fuse[0] ? MCVS_BOOT_256 : MCVS_BOOT_512) :
		(boot_size_fuse[0] ? MCVS_BOOT_1K : MCVS_BOOT_2K);
	wire logic [12:0] ra = boot_reset_fuse ? 13'h0000 : bs;

	// Single domain, so clock and reset are given once
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	property p_hit;
		1 |=> bus_hit == $past(hc);
	endproperty
	a_hit: assert property (p_hit) else $error("bus_hit wrong");
	property p_pud;
		bus_wr && hc |=> pullup_global_off == $past(bus_wdata[4]);
	endproperty
	a_pud: assert property (p_pud) else $error("pull-up bit");
	property p_rd0;
		!rdh |=> bus_rdata == 8'h00;
	endproperty
	a_rd0: assert property (p_rd0) else $error("idle rdata");
	// Reserved bits read zero; bits 4 and 6 mirror the pull-up and request outputs
	property p_rdb;
		rdh |=> bus_rdata[7] == 1'b0 && bus_rdata[3:2] == 2'b00 &&
			bus_rdata[4] == $past(pullup_global_off) &&
			bus_rdata[6] == $past(bod_sleep_active);
	endproperty
	a_rdb: assert property (p_rdb) else $error("read bits");
	property p_bod_sleep_request;
		$rose(bod_sleep_active) |-> bod_sleep_active[*3] ##1
			!bod_sleep_active;
	endproperty
	a_bod_sleep_request: assert property (p_bod_sleep_request) else $error("request life");
	property p_boff;
		bod_sleep_active && sleep_exec |=> bod_off;
	endproperty
	a_boff: assert property (p_boff) else $error("detector on");
	property p_blk;
		wu |=> irq_block[*2];
	endproperty
	a_blk: assert property (p_blk) else $error("not blocked");
	// Without a select write the block lasts four cycles only
	property p_tmo;
		wu ##1 (!bus_wr && nolock)[*4] |=> !irq_block;
	endproperty
	a_tmo: assert property (p_tmo) else $error("block stuck");
	property p_rst;
		1 |=> reset_addr == $past(ra);
	endproperty
	a_rst: assert property (p_rst) else $error("reset addr");

	c_move: cover property (wu ##2 bus_wr);
	c_boff: cover property ($rose(bod_off));
	c_lock: cover property ($rose(irq_block) && !nolock);
endmodule

bind mcvs_top mcvs_checker i_chk (.clock, .rst_n, .bus_addr, .bus_io,
	.bus_wr, .bus_rd, .bus_wdata, .bus_rdata, .bus_hit, .sleep_exec,
	.boot_reset_fuse, .boot_size_fuse, .app_boot_lock_bit,
	.boot_boot_lock_bit, .irq_block, .pullup_global_off,
	.bod_sleep_active, .bod_off, .reset_addr);

//--- mcu_control_vector_select_tb.sv
module mcu_control_vector_select_tb
	import mcvs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clock = '0, rst_n = '0;
	logic [7:0]  bus_addr = '0, bus_wdata = '0, bus_rdata;
	logic        bus_io = '0, bus_wr = '0, bus_rd = '0, bus_hit;
	logic        instr_done = '0, sleep_exec = '0, wake = '0;
	logic [12:0] pc = '0, vector_base, reset_addr;
	logic        boot_reset_fuse = '1, app_boot_lock_bit = '1;
	logic        boot_boot_lock_bit = '1;
	logic [1:0]  boot_size_fuse = 2'h1;
	logic        irq_block, pullup_global_off, bod_sleep_active, bod_off;
	int          num_errors = 0, check_count = 0;
	logic [12:0] st [4];

	mcvs_top i_dut (.clock, .rst_n, .bus_addr, .bus_io, .bus_wr, .bus_rd,
		.bus_wdata, .bus_rdata, .bus_hit, .instr_done, .sleep_exec, .wake,
		.pc, .boot_reset_fuse, .boot_size_fuse, .app_boot_lock_bit,
		.boot_boot_lock_bit, .irq_block, .pullup_global_off,
		.bod_sleep_active, .bod_off, .vector_base, .reset_addr);

	// 10 MHz clock
	always #50 clock = ~clock;

	// ------------------------------------------------
	// Drivers, always 10 ns after the edge
	// ------------------------------------------------
	task step(input int n);
		repeat (n) @(posedge clock);
		#10;
	endtask
	task chk(input string s, input logic [12:0] g, input logic [12:0] e);
		check_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	// Each driver opens with an edge, so strobes never toggle twice at once
	task wr(input logic [7:0] d);
		step(1);
		bus_io = 1'b0;
		bus_addr = MCVS_DS_OFF;
		bus_wdata = d;
		bus_wr = 1'b1;
		step(1);
		bus_wr = 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic io, h, input logic [7:0] e);
		step(1);
		bus_io = io;
		bus_addr = a;
		bus_rd = 1'b1;
		step(1);
		bus_rd = 1'b0;
		chk("bus_hit", 13'(bus_hit), 13'(h));
		chk("bus_rdata", 13'(bus_rdata), 13'(e));
	endtask

	// ------------------------------------------------
	// Scenarios
	// ------------------------------------------------
	task t_reset();
		chk("vector_base", vector_base, 13'h0002);
		chk("irq_block", 13'(irq_block), 13'h0000);
		rd(MCVS_DS_OFF, 1'b0, 1'b1, 8'h00);
		rd(MCVS_IO_OFF, 1'b1, 1'b1, 8'h00);
		rd(MCVS_DS_OFF, 1'b1, 1'b0, 8'h00);
		rd(8'h56, 1'b0, 1'b0, 8'h00);
	endtask
	task t_pud();
		wr(8'h10);
		chk("pullup", 13'(pullup_global_off), 13'h0001);
		rd(MCVS_IO_OFF, 1'b1, 1'b1, 8'h10);
		wr(8'h00);
		chk("pullup", 13'(pullup_global_off), 13'h0000);
	endtask
	// Lock bit programmed, running where the vectors are not
	task t_lock(input logic app);
		app_boot_lock_bit = ~app;
		boot_boot_lock_bit = app;
		pc = app ? 13'h0100 : 13'h1C10;
		step(3);
		chk("irq_block", 13'(irq_block), 13'h0001);
		pc = app ? 13'h1C10 : 13'h0100;
		step(3);
		chk("irq_block", 13'(irq_block), 13'h0000);
		app_boot_lock_bit = 1'b1;
		boot_boot_lock_bit = 1'b1;
	endtask
	task t_tmo();
		wr(8'h02);
		rd(MCVS_DS_OFF, 1'b0, 1'b1, 8'h00);
		// Unlock only: sampled in the third window cycle, then the fifth
		wr(8'h01);
		chk("irq_block", 13'(irq_block), 13'h0001);
		step(1);
		rd(MCVS_DS_OFF, 1'b0, 1'b1, 8'h01);
		chk("irq_block", 13'(irq_block), 13'h0001);
		rd(MCVS_DS_OFF, 1'b0, 1'b1, 8'h00);
		chk("irq_block", 13'(irq_block), 13'h0000);
	endtask
	// Block outlives the four cycles until an instruction completes
	task t_move();
		wr(8'h01);
		wr(8'h02);
		step(5);
		chk("irq_block", 13'(irq_block), 13'h0001);
		instr_done = 1'b1;
		step(1);
		instr_done = 1'b0;
		chk("irq_block", 13'(irq_block), 13'h0000);
		rd(MCVS_DS_OFF, 1'b0, 1'b1, 8'h02);
		chk("vector_base", vector_base, 13'h1C02);
	endtask
	task t_fuse();
		for (int f = 0; f < 4; f++)
		begin
			boot_size_fuse = 2'(f);
			boot_reset_fuse = 1'b0;
			step(2);
			chk("vector_base", vector_base, st[f] + 13'h0002);
			chk("reset_addr", reset_addr, st[f]);
			boot_reset_fuse = 1'b1;
			step(2);
			chk("reset_addr", reset_addr, 13'h0000);
		end
		boot_size_fuse = 2'h1;
	endtask
	task t_bod();
		wr(8'h40);
		chk("bod_active", 13'(bod_sleep_active), 13'h0000);
		// Request write lands in the last cycle of the unlock window
		wr(8'h60);
		rd(MCVS_DS_OFF, 1'b0, 1'b1, 8'h22);
		wr(8'h40);
		sleep_exec = 1'b1;
		step(1);
		sleep_exec = 1'b0;
		step(1);
		chk("bod_off", 13'(bod_off), 13'h0001);
		chk("bod_active", 13'(bod_sleep_active), 13'h0001);
		step(1);
		chk("bod_active", 13'(bod_sleep_active), 13'h0000);
		rd(MCVS_DS_OFF, 1'b0, 1'b1, 8'h02);
		wake = 1'b1;
		step(1);
		wake = 1'b0;
		step(1);
		chk("bod_off", 13'(bod_off), 13'h0000);
	endtask

	task print_verdict();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Watchdog: tests need under a hundred cycles
	initial
	begin
		#200000;
		num_errors++;
		print_verdict();
	end

	initial
	begin
		st = '{MCVS_BOOT_2K, MCVS_BOOT_1K, MCVS_BOOT_512, MCVS_BOOT_256};
		step(3);
		rst_n = 1'b1;
		t_reset();
		t_pud();
		t_lock(1'b0);
		t_tmo();
		t_move();
		t_fuse();
		t_lock(1'b1);
		t_bod();
		print_verdict();
	end
endmodule
